// file: cspi_defs.svh
// Constants for the core status, power and interrupt-enable register bank.
`ifndef CSPI_DEFS_SVH
`define CSPI_DEFS_SVH
`define CSPI_ADDR_PSW      4'h0
`define CSPI_ADDR_POWER_CONTROL     4'h4
`define CSPI_ADDR_IEN      4'h8
`define CSPI_ADDR_ACC      4'hc
`define CSPI_PSW_RST       8'h00
`define CSPI_POWER_CONTROL_RST      8'h00
`define CSPI_IEN_RST       8'h00
`define CSPI_PSW_PAR       0
`define CSPI_PSW_UF1       1
`define CSPI_PSW_BANK_LO   3
`define CSPI_PSW_BANK_HI   4
`define CSPI_PSW_UFA       5
`define CSPI_PSW_OV        2
`define CSPI_PSW_AC        6
`define CSPI_PSW_CY        7
`define CSPI_PSW_WMASK     8'hfe
`define CSPI_POWER_CONTROL_IDL      0
`define CSPI_POWER_CONTROL_PD       1
`define CSPI_POWER_CONTROL_BAUD     7
`define CSPI_POWER_CONTROL_MASK     8'h8f
`define CSPI_IEN_GATE      7
`define CSPI_IEN_MASK      8'h9f
`define CSPI_VEC_PIN0      16'h0003
`define CSPI_VEC_TMR0      16'h000b
`define CSPI_VEC_PIN1      16'h0013
`define CSPI_VEC_TMR1      16'h001b
`define CSPI_VEC_SER       16'h0023
`define CSPI_BANK_SHIFT    3
`endif

// file: cspi_pkg.sv
// Types for the core status, power and interrupt-enable register bank.
package cspi_pkg;
    typedef enum logic [1:0] {CSPI_RUN, CSPI_IDLE, CSPI_PDOWN} cspi_pwr_e;
    typedef logic [7:0] cspi_byte_t;
endpackage

// file: cspi_irq_sel.sv
// Interrupt source qualification, priority pick and vector output.
`timescale 1ns/1ps
`include "cspi_defs.svh"
module cspi_irq_sel (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  ien,
    input  wire logic        trig0,
    input  wire logic        trig1,
    input  wire logic        pin0,
    input  wire logic        pin1,
    input  wire logic [2:0]  flags,
    input  wire logic        ack,
    output logic             req,
    output logic [15:0]      vec,
    output logic [2:0]       src
);
    typedef struct packed {
        logic prev0;
        logic prev1;
        logic edge0;
        logic edge1;
    } cspi_sel_s;
    cspi_sel_s st;
    cspi_sel_s next_st;
    logic [4:0] pend;
    logic [4:0] live;
    always_comb begin
        next_st       = st;
        next_st.prev0 = pin0;
        next_st.prev1 = pin1;
        // Falling edge latches; acknowledge of that source clears, but a new edge wins.
        if (ack && src == 3'h0) begin
            next_st.edge0 = 1'b0;
        end
        if (ack && src == 3'h2) begin
            next_st.edge1 = 1'b0;
        end
        if (st.prev0 && !pin0) begin
            next_st.edge0 = 1'b1;
        end
        if (st.prev1 && !pin1) begin
            next_st.edge1 = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Pins idle high, so the edge detector starts at the idle level.
            st       <= '0;
            st.prev0 <= 1'b1;
            st.prev1 <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
    always_comb begin
        pend[0] = trig0 ? st.edge0 : !pin0;
        pend[1] = flags[0];
        pend[2] = trig1 ? st.edge1 : !pin1;
        pend[3] = flags[1];
        pend[4] = flags[2];
        live    = pend & ien[4:0] & {5{ien[`CSPI_IEN_GATE]}};
        req     = |live;
        src     = 3'h0;
        vec     = `CSPI_VEC_PIN0;
        if (live[0]) begin
            src = 3'h0;
            vec = `CSPI_VEC_PIN0;
        end else if (live[1]) begin
            src = 3'h1;
            vec = `CSPI_VEC_TMR0;
        end else if (live[2]) begin
            src = 3'h2;
            vec = `CSPI_VEC_PIN1;
        end else if (live[3]) begin
            src = 3'h3;
            vec = `CSPI_VEC_TMR1;
        end else if (live[4]) begin
            src = 3'h4;
            vec = `CSPI_VEC_SER;
        end
    end
endmodule

// file: cspi_regs.sv
// Status word, power control and interrupt enable registers on an Avalon-MM slave.
//
// Notes on behaviour
// - Parity bit tracks odd count of ones in the accumulator every cycle.
// - Bank select bits map working registers onto one of four 8-byte banks.
// - Status bits 5 and 1 are plain software flags.
// - Baud doubler bit doubles the serial rate when timer 1 clocks it; the code doubles only when SERIAL_MODE is also not 0.
// - Writing 1 to the deep sleep bit enters power-down.
// - Writing 1 to the light sleep bit enters idle.
// - Both sleep bits written together: power-down wins.
// - Global gate low blocks every interrupt request.
// - Global gate high lets each source follow its own enable.
// - Individual enables sit at bits 4 down to 0.
// - Acknowledged source branches to its fixed vector.
// - Trigger select 0 means level, 1 means falling transition.
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "cspi_defs.svh"
module cspi_regs
    import cspi_pkg::*;
(
    input  wire logic                 SYS_CLK,
    input  wire logic                 RST_N,
    input  wire logic [3:0]           AVS_ADDRESS,
    input  wire logic                 AVS_READ,
    input  wire logic                 AVS_WRITE,
    input  wire logic [31:0]          AVS_WRITEDATA,
    input  wire logic [3:0]           AVS_BYTEENABLE,
    output logic [31:0]               AVS_READDATA,
    output logic                      AVS_WAITREQUEST,
    input  wire logic                 CARRY_OUT_FLAG,
    input  wire logic                 HALF_CARRY_FLAG,
    input  wire logic                 SIGNED_WRAP_FLAG,
    input  wire logic                 FLAGS_LOAD,
    input  wire logic                 PIN0_IRQ_INPUT,
    input  wire logic                 PIN1_IRQ_INPUT,
    input  wire logic                 PIN0_TRIGGER_SELECT,
    input  wire logic                 PIN1_TRIGGER_SELECT,
    input  wire logic                 TIMER0_WRAP_FLAG,
    input  wire logic                 TIMER1_WRAP_FLAG,
    input  wire logic                 RX_DONE_FLAG,
    input  wire logic                 TX_DONE_FLAG,
    input  wire logic                 TIMER1_BAUD_SRC,
    input  wire logic [1:0]           SERIAL_MODE,
    input  wire logic                 IRQ_ACK,
    input  wire logic                 WAKE,
    output logic [4:0]                BANK_BASE,
    output logic                      BAUD_DOUBLE,
    output cspi_pkg::cspi_pwr_e       POWER_STATE,
    output logic                      IRQ_REQ,
    output logic [15:0]               IRQ_VECTOR
);
    import cspi_pkg::*;

    typedef struct packed {
        cspi_byte_t processor_status_word;
        cspi_byte_t power_control;
        cspi_byte_t ien;
        cspi_byte_t acc;
        cspi_pwr_e  pwr;
        logic [1:0] p0_sync;
        logic [1:0] p1_sync;
        logic [31:0] rdata;
        logic       waitreq;
        logic [4:0] bank;
        logic       baud;
        logic       irq;
        logic [15:0] vec;
    } cspi_regs_s;

    cspi_regs_s st;
    cspi_regs_s next_st;
    logic       sel_req;
    logic [15:0] sel_vec;

    // Merges a written byte into a register under a writable mask.
    function automatic cspi_byte_t merge(input cspi_byte_t old, input cspi_byte_t wd,
                                         input cspi_byte_t mask);
        merge = (old & ~mask) | (wd & mask);
    endfunction

    cspi_irq_sel u_sel (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .ien   (st.ien),
        .trig0 (PIN0_TRIGGER_SELECT),
        .trig1 (PIN1_TRIGGER_SELECT),
        .pin0  (st.p0_sync[1]),
        .pin1  (st.p1_sync[1]),
        .flags ({RX_DONE_FLAG | TX_DONE_FLAG, TIMER1_WRAP_FLAG, TIMER0_WRAP_FLAG}),
        .ack   (IRQ_ACK && st.pwr != CSPI_PDOWN),
        .req   (sel_req),
        .vec   (sel_vec),
        .src   ()
    );

    always_comb begin
        logic       do_wr;
        logic       do_rd;
        cspi_byte_t wb;
        next_st = st;
        wb      = AVS_WRITEDATA[7:0];
        // A write lands only at the edge that ends the waitrequest-low cycle.
        do_wr   = AVS_WRITE && !st.waitreq && AVS_BYTEENABLE[0];
        // Read data is captured one edge early so it stands while waitrequest is low.
        do_rd   = AVS_READ && st.waitreq;
        next_st.p0_sync = {st.p0_sync[0], PIN0_IRQ_INPUT};
        next_st.p1_sync = {st.p1_sync[0], PIN1_IRQ_INPUT};
        // Every request is answered one cycle after it is seen, then waitrequest rises.
        next_st.waitreq = !((AVS_READ || AVS_WRITE) && st.waitreq);
        next_st.rdata  = '0;
        if (FLAGS_LOAD) begin
            next_st.processor_status_word[`CSPI_PSW_CY] = CARRY_OUT_FLAG;
            next_st.processor_status_word[`CSPI_PSW_AC] = HALF_CARRY_FLAG;
            next_st.processor_status_word[`CSPI_PSW_OV] = SIGNED_WRAP_FLAG;
        end
        if (do_wr) begin
            case (AVS_ADDRESS)
                `CSPI_ADDR_PSW: begin
                    next_st.processor_status_word = merge(st.processor_status_word, wb, `CSPI_PSW_WMASK);
                end
                `CSPI_ADDR_POWER_CONTROL: begin
                    next_st.power_control = merge(st.power_control, wb, `CSPI_POWER_CONTROL_MASK);
                    if (wb[`CSPI_POWER_CONTROL_PD]) begin
                        next_st.pwr = CSPI_PDOWN;
                    end else if (wb[`CSPI_POWER_CONTROL_IDL]) begin
                        next_st.pwr = CSPI_IDLE;
                    end
                end
                `CSPI_ADDR_IEN: begin
                    next_st.ien = merge(st.ien, wb, `CSPI_IEN_MASK);
                end
                `CSPI_ADDR_ACC: begin
                    next_st.acc = wb;
                end
                default: begin
                    next_st.acc = st.acc;
                end
            endcase
        end
        if (do_rd) begin
            case (AVS_ADDRESS)
                `CSPI_ADDR_PSW:  next_st.rdata = {24'h000000, st.processor_status_word};
                `CSPI_ADDR_POWER_CONTROL: next_st.rdata = {24'h000000, st.power_control};
                `CSPI_ADDR_IEN:  next_st.rdata = {24'h000000, st.ien};
                `CSPI_ADDR_ACC:  next_st.rdata = {24'h000000, st.acc};
                default:         next_st.rdata = 32'h00000000;
            endcase
        end
        next_st.processor_status_word[`CSPI_PSW_PAR] = ^next_st.acc;
        // Sleep modes end on wake; an accepted interrupt also ends idle.
        if (WAKE || (st.pwr == CSPI_IDLE && sel_req)) begin
            if (!(do_wr && AVS_ADDRESS == `CSPI_ADDR_POWER_CONTROL
                  && (wb[`CSPI_POWER_CONTROL_PD] || wb[`CSPI_POWER_CONTROL_IDL]))) begin
                next_st.pwr = CSPI_RUN;
            end
        end
        if (next_st.pwr == CSPI_RUN) begin
            next_st.power_control[`CSPI_POWER_CONTROL_PD]  = 1'b0;
            next_st.power_control[`CSPI_POWER_CONTROL_IDL] = 1'b0;
        end
        next_st.bank = 5'(next_st.processor_status_word[`CSPI_PSW_BANK_HI:`CSPI_PSW_BANK_LO])
                       << `CSPI_BANK_SHIFT;
        next_st.baud = next_st.power_control[`CSPI_POWER_CONTROL_BAUD] && TIMER1_BAUD_SRC
                       && SERIAL_MODE != 2'h0;
        next_st.irq  = sel_req && st.pwr != CSPI_PDOWN;
        next_st.vec  = sel_vec;
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            st      <= '0;
            st.processor_status_word  <= `CSPI_PSW_RST;
            st.power_control <= `CSPI_POWER_CONTROL_RST;
            st.ien  <= `CSPI_IEN_RST;
            st.pwr  <= CSPI_RUN;
            st.waitreq <= 1'b1;
            st.vec  <= `CSPI_VEC_PIN0;
            // Pin synchronisers start at the idle high level of the pins.
            st.p0_sync <= '1;
            st.p1_sync <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign AVS_READDATA    = st.rdata;
    assign AVS_WAITREQUEST = st.waitreq;
    assign BANK_BASE       = st.bank;
    assign BAUD_DOUBLE     = st.baud;
    assign POWER_STATE     = st.pwr;
    assign IRQ_REQ         = st.irq;
    assign IRQ_VECTOR      = st.vec;
endmodule

// file: cspi_regs_props.sv
// Concurrent checks on the status, power and interrupt-enable register bank.
`timescale 1ns/1ps
module cspi_regs_props
    import cspi_pkg::*;
(
    input wire logic           SYS_CLK,
    input wire logic           RST_N,
    input wire logic [3:0]     AVS_ADDRESS,
    input wire logic           AVS_READ,
    input wire logic           AVS_WRITE,
    input wire logic [31:0]    AVS_WRITEDATA,
    input wire logic [3:0]     AVS_BYTEENABLE,
    input wire logic [31:0]    AVS_READDATA,
    input wire logic           AVS_WAITREQUEST,
    input wire logic           TIMER1_BAUD_SRC,
    input wire logic [1:0]     SERIAL_MODE,
    input wire logic [4:0]     BANK_BASE,
    input wire logic           BAUD_DOUBLE,
    input cspi_pkg::cspi_pwr_e POWER_STATE,
    input wire logic           IRQ_REQ,
    input wire logic [15:0]    IRQ_VECTOR
);
    logic [7:0] acc;
    logic       gate;
    wire        wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
    // Shadows of the accumulator and global gate, as software last wrote them.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            acc <= 8'h00;
            gate <= 1'b0;
        end else if (wr_ok && AVS_ADDRESS == 4'hc) begin
            acc <= AVS_WRITEDATA[7:0];
        end else if (wr_ok && AVS_ADDRESS == 4'h8) begin
            gate <= AVS_WRITEDATA[7];
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    a_wait_one_cycle:
    assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("wait low too long");
    a_read_idle_zero:
    assert property (AVS_WAITREQUEST |-> AVS_READDATA == 32'h0) else $error("stray read data");
    a_parity_track:
    assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h0
        |-> AVS_READDATA[0] == ^acc) else $error("parity bit wrong");
    a_bank_base_set:
    assert property (wr_ok && AVS_ADDRESS == 4'h0
        |=> BANK_BASE == {$past(AVS_WRITEDATA[4:3]), 3'h0}) else $error("bank base wrong");
    a_pdown_wins:
    assert property (wr_ok && AVS_ADDRESS == 4'h4 && AVS_WRITEDATA[1]
        |=> POWER_STATE == CSPI_PDOWN) else $error("power-down not entered");
    a_idle_entry:
    assert property (wr_ok && AVS_ADDRESS == 4'h4 && AVS_WRITEDATA[1:0] == 2'h1
        && POWER_STATE == CSPI_RUN |=> POWER_STATE == CSPI_IDLE) else $error("idle not entered");
    a_gate_closed:
    assert property (!gate && !$past(gate) && !$past(gate, 2) |-> !IRQ_REQ)
        else $error("request with gate closed");
    a_vector_legal:
    assert property (IRQ_REQ |-> IRQ_VECTOR inside {16'h0003, 16'h000b, 16'h0013,
        16'h001b, 16'h0023}) else $error("illegal vector");
    a_baud_cause:
    assert property (BAUD_DOUBLE |-> $past(TIMER1_BAUD_SRC) && $past(SERIAL_MODE) != 2'h0)
        else $error("baud doubled without cause");
endmodule
bind cspi_regs cspi_regs_props u_props (.*);

// file: tb.sv
// Self-checking bench for the status, power and interrupt-enable register bank.
`timescale 1ns/1ps
module tb;
    import cspi_pkg::*;
    logic SYS_CLK = 0, RST_N = 0, AVS_READ = 0, AVS_WRITE = 0, WAKE = 0, IRQ_ACK = 0;
    logic FLAGS_LOAD = 0, CARRY_OUT_FLAG = 0, HALF_CARRY_FLAG = 0, SIGNED_WRAP_FLAG = 0;
    logic TIMER1_BAUD_SRC = 0, trig = 0;
    logic [3:0] AVS_ADDRESS = 0, AVS_BYTEENABLE = 4'hf;
    logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA, rd;
    logic [1:0] SERIAL_MODE = 0;
    logic [5:0] src = 0;
    logic AVS_WAITREQUEST, BAUD_DOUBLE, IRQ_REQ;
    logic [4:0] BANK_BASE;
    logic [15:0] IRQ_VECTOR;
    cspi_pwr_e POWER_STATE;
    int failures = 0, num_checks = 0;
    // Pins are active low; src bit 1 means that source is requesting.
    wire PIN0_IRQ_INPUT = !src[0], TIMER0_WRAP_FLAG = src[1], PIN1_IRQ_INPUT = !src[2];
    wire TIMER1_WRAP_FLAG = src[3], TX_DONE_FLAG = src[4], RX_DONE_FLAG = src[5];
    wire PIN0_TRIGGER_SELECT = trig, PIN1_TRIGGER_SELECT = trig;
    cspi_regs u_cspi_regs (.*);
    always #20 SYS_CLK = ~SYS_CLK;
    task automatic check(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do begin
            @(posedge SYS_CLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_WRITE <= 0;
        AVS_READ <= 0;
        @(posedge SYS_CLK);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        bus(0, a, 0);
        check(rd, e);
    endtask
    task automatic t_status;
        for (int b = 0; b < 4; b++) begin
            bus(1, 4'h0, 8'he7 | (b << 3));
            check(BANK_BASE, b * 8);
            rdc(4'h0, 8'he6 | (b << 3));
        end
        AVS_BYTEENABLE <= 4'he;
        bus(1, 4'h0, 0);
        AVS_BYTEENABLE <= 4'hf;
        rdc(4'h0, 8'hfe);
        rdc(4'h2, 0);
        bus(1, 4'hc, 8'h07);
        rdc(4'h0, 8'hff);
        bus(1, 4'hc, 8'h03);
        rdc(4'h0, 8'hfe);
    endtask
    task automatic t_power;
        bus(1, 4'h4, 8'h8c);
        rdc(4'h4, 8'h8c);
        for (int i = 1; i < 4; i++) begin
            bus(1, 4'h4, i);
            check(POWER_STATE, i == 1 ? CSPI_IDLE : CSPI_PDOWN);
            WAKE <= 1;
            tick(1);
            WAKE <= 0;
            tick(2);
            check(POWER_STATE, CSPI_RUN);
        end
        bus(1, 4'h4, 8'h80);
        for (int m = 0; m < 8; m++) begin
            TIMER1_BAUD_SRC <= m[2];
            SERIAL_MODE <= m[1:0];
            tick(3);
            check(BAUD_DOUBLE, m[2] && m[1:0] != 0);
        end
    endtask
    task automatic t_irq;
        int k;
        bus(1, 4'h8, 8'h9f);
        rdc(4'h8, 8'h9f);
        for (int i = 0; i < 6; i++) begin
            k = i > 4 ? 4 : i;
            src <= 6'h1 << i;
            bus(1, 4'h8, 8'h80 | (1 << k));
            tick(4);
            check({IRQ_REQ, IRQ_VECTOR}, {1'b1, 16'h3 + 16'(8 * k)});
            bus(1, 4'h8, 8'h1f);
            tick(2);
            check(IRQ_REQ, 0);
            bus(1, 4'h8, 8'h80 | (8'h1f ^ (1 << k)));
            tick(2);
            check(IRQ_REQ, 0);
        end
        src <= 0;
        trig <= 1;
        bus(1, 4'h8, 8'h81);
        // Drop the edge latched during the level scenarios before testing a fresh one.
        IRQ_ACK <= 1;
        tick(1);
        IRQ_ACK <= 0;
        tick(3);
        check(IRQ_REQ, 0);
        src <= 1;
        tick(2);
        src <= 0;
        tick(6);
        check(IRQ_REQ, 1);
        IRQ_ACK <= 1;
        tick(1);
        IRQ_ACK <= 0;
        tick(3);
        check(IRQ_REQ, 0);
        trig <= 0;
        src <= 1;
        tick(5);
        check(IRQ_REQ, 1);
        src <= 0;
        tick(5);
        check(IRQ_REQ, 0);
    endtask
    task automatic final_report;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge SYS_CLK);
        RST_N <= 1;
        @(posedge SYS_CLK);
        check(IRQ_VECTOR, 16'h0003);
        rdc(4'h4, 0);
        t_status;
        t_power;
        t_irq;
        final_report;
    end
    initial begin
        repeat (5000) @(posedge SYS_CLK);
        failures++;
        final_report;
    end
endmodule
